// [verilog/pmc_power_ctrl.sv]
/*
 * pmc_power_ctrl.sv - run, wait and stop power modes, peripheral clock
 * gating, bus clock source selection and pin states in low power.
 * Assumes: control inputs and core-side pin values come from logic on
 * mclk_in; sub_clock_in is an asynchronous oscillator pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"

// Contract
// R1 - writing all-clock stop enters stop mode
// R2 - stop halts bus, peripheral, sub, converter clocks
// R3 - stop: only external-clocked timers and serial run
// R4 - stop exits by reset or enabled interrupt
// R5 - divide-by-8 set on reset, fast stop entry
// R6 - stop external bus: hold buses, strobes high
// R7 - single-chip stop: sub output high, divided hold
// R8 - wait instruction stops bus clock and watchdog
// R9 - wait bit also gates peripheral clocks
// R10 - wait exits to service routine, same clock
// R11 - wait: pins hold, external strobes driven high
// R12 - wait clock output toggles unless gated
// R13 - reset starts bus clock at divide-by-8
// R14 - divided modes divide main clock accordingly
// R15 - software waits for stable oscillators first
// R16 - divider field picks 1,2,4,16 unless forced
// R17 - low-speed uses sub-clock as bus clock
// R18 - wait peripheral stop bit in control word
// R19 - clock changes never make short pulses
module pmc_power_ctrl (
    // clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_b_in,
    // control from the core
    input  wire logic               ctrl_wr_in,
    input  wire pmc_pkg::pmc_ctrl_t ctrl_in,
    input  wire logic               stop_req_in,
    input  wire logic               wait_instr_in,
    input  wire logic               irq_wake_in,
    input  wire logic               ext_bus_mode_in,
    input  wire logic               timer_ext_event_in,
    input  wire logic               serial_ext_clk_in,
    // pin values from the core and oscillator pin
    input  wire logic               sub_clock_in,
    input  wire pmc_pkg::pmc_bus_t  bus_core_in,
    input  wire logic [7:0]         port_core_in,
    input  wire logic               cko_port_in,
    // status
    output pmc_pkg::pmc_ctrl_t      ctrl_out,
    output logic                    stop_mode_out,
    output logic                    wait_mode_out,
    output logic                    isr_start_out,
    // clock gates
    output logic                    main_osc_en_out,
    output logic                    sub_osc_en_out,
    output logic                    periph_clk_en_out,
    output logic                    converter_clk_en_out,
    output logic                    wdt_clk_en_out,
    output logic                    sub_deriv_en_out,
    output logic                    timer_clk_en_out,
    output logic                    serial_clk_en_out,
    output logic                    bus_tick_out,
    // pins
    output pmc_pkg::pmc_bus_t       bus_pin_out,
    output logic [7:0]              port_pin_out,
    output logic                    clock_output_pin_out
);
    import pmc_pkg::*;

    pmc_state_t             state_ff;
    pmc_state_t             nxt_state;
    pmc_ctrl_t              nxt_ctrl;
    pmc_ctrl_t              ctrl_wr;
    pmc_src_t               sel_src;
    pmc_bus_t               nxt_bus;
    logic [`PMC_PRE_W-1:0]  pre_ff;
    logic                   sub_lvl;
    logic                   sub_prev_ff;
    logic                   sub_tick;
    logic                   bclk_phase;
    logic                   go_stop;
    logic                   go_wait;
    logic                   wake;
    logic                   nxt_run;
    logic                   nxt_wait;
    logic                   nxt_stop;
    logic                   nxt_periph;
    logic                   nxt_cko;

    // sub-clock pin crosses in through two flops, then edge detect
    pmc_sync #(
        .WIDTH (1)
    ) u_sub_sync (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .async_in (sub_clock_in),
        .sync_out (sub_lvl)
    );
    assign sub_tick = sub_lvl & ~sub_prev_ff;

    // mode events; stop wins over a wait in the same cycle
    assign go_stop = (state_ff == PMC_ST_RUN) && stop_req_in;                     // R1
    assign go_wait = (state_ff == PMC_ST_RUN) && wait_instr_in && !stop_req_in;   // R8
    assign wake    = (state_ff != PMC_ST_RUN) && irq_wake_in;                     // R4 R10

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            PMC_ST_RUN:
            begin
                if (go_stop)
                    nxt_state = PMC_ST_STOP;
                else if (go_wait)
                    nxt_state = PMC_ST_WAIT;
            end
            PMC_ST_WAIT, PMC_ST_STOP:
            begin
                if (wake)
                    nxt_state = PMC_ST_RUN;
            end
            default: nxt_state = PMC_ST_RUN;
        endcase
    end

    assign nxt_run  = (nxt_state == PMC_ST_RUN);
    assign nxt_wait = (nxt_state == PMC_ST_WAIT);
    assign nxt_stop = (nxt_state == PMC_ST_STOP);

    // writes only land while the core runs, so wait keeps its clock
    assign ctrl_wr = (ctrl_wr_in && state_ff == PMC_ST_RUN) ? ctrl_in : ctrl_out;  // R10

    // stop entry from a main-clock mode forces divide-by-8; hardware wins
    always_comb
    begin
        nxt_ctrl = ctrl_wr;
        if (go_stop && !ctrl_wr.system_clock_select)
            nxt_ctrl.div8_select = 1'b1;                                          // R5
    end

    // bus clock source decode
    assign sel_src = ctrl_out.system_clock_select ? PMC_SRC_SUB :                 // R17
                     ctrl_out.div8_select         ? PMC_SRC_DIV8 :                // R13
                     ({ctrl_out.divider_field_high, ctrl_out.divider_field_low}
                         == `PMC_DIVF_1) ? PMC_SRC_DIV1 :                         // R16
                     ({ctrl_out.divider_field_high, ctrl_out.divider_field_low}
                         == `PMC_DIVF_2) ? PMC_SRC_DIV2 :
                     ({ctrl_out.divider_field_high, ctrl_out.divider_field_low}
                         == `PMC_DIVF_4) ? PMC_SRC_DIV4 : PMC_SRC_DIV16;

    pmc_bclk_gen u_bclk (
        .mclk_in     (mclk_in),
        .rst_b_in    (rst_b_in),
        .run_in      (nxt_run),                       // R8 halts with the mode flag, no stray tick
        .src_in      (sel_src),                                                   // R14
        .sub_tick_in (sub_tick),
        .sub_lvl_in  (sub_lvl),
        .tick_out    (bus_tick_out),
        .phase_out   (bclk_phase)
    );

    // peripheral clocks: off in stop, off in wait when the stop bit is set
    assign nxt_periph = !nxt_ctrl.main_clock_stop &&
                        (nxt_run || (nxt_wait && !nxt_ctrl.wait_periph_clock_stop)); // R2 R9

    // clock output: divided taps hold in stop and in gated wait, where the prescaler freezes
    assign nxt_cko = ext_bus_mode_in ? (nxt_run ? cko_port_in : clock_output_pin_out) :
                     (nxt_ctrl.clk_out_sel == `PMC_CKO_SUB)  ? (nxt_stop | sub_lvl) : // R7 R12
                     (nxt_ctrl.clk_out_sel == `PMC_CKO_F8)   ? pre_ff[`PMC_F8_BIT] :
                     (nxt_ctrl.clk_out_sel == `PMC_CKO_F32)  ? pre_ff[`PMC_F32_BIT] :
                     (nxt_run ? cko_port_in : clock_output_pin_out);

    // pins: run follows the core, low power holds buses and, in external bus mode, idles strobes
    always_comb
    begin
        nxt_bus           = bus_core_in;
        nxt_bus.bus_clock = bclk_phase;
        if (!nxt_run)
        begin
            nxt_bus = bus_pin_out;                                                // R6 R11
            if (ext_bus_mode_in)
            begin
                nxt_bus.read_b              = 1'b1;                               // R6 R11
                nxt_bus.write_b             = 1'b1;
                nxt_bus.write_low_strobe_b  = 1'b1;
                nxt_bus.write_high_strobe_b = 1'b1;
                nxt_bus.hold_acknowledge_b  = 1'b1;
                nxt_bus.addr_latch          = 1'b1;
                nxt_bus.bus_clock           = 1'b1;
            end
        end
    end

    // mode and control state
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            state_ff      <= PMC_ST_RUN;
            ctrl_out      <= `PMC_CTRL_RST;                                       // R5 R13
            isr_start_out <= 1'b0;
            sub_prev_ff   <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            ctrl_out      <= nxt_ctrl;                                            // R18
            isr_start_out <= wake;                                                // R4 R10
            sub_prev_ff   <= sub_lvl;
        end
    end

    // registered status and gates, aligned with the mode flags
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            stop_mode_out        <= 1'b0;
            wait_mode_out        <= 1'b0;
            main_osc_en_out      <= 1'b1;
            sub_osc_en_out       <= 1'b1;
            periph_clk_en_out    <= 1'b1;
            converter_clk_en_out <= 1'b1;
            wdt_clk_en_out       <= 1'b1;
            sub_deriv_en_out     <= 1'b1;
            timer_clk_en_out     <= 1'b1;
            serial_clk_en_out    <= 1'b1;
        end
        else
        begin
            stop_mode_out        <= nxt_stop;
            wait_mode_out        <= nxt_wait;
            main_osc_en_out      <= !nxt_stop && !nxt_ctrl.main_clock_stop;       // R1 R8
            sub_osc_en_out       <= !nxt_stop;                                    // R1
            periph_clk_en_out    <= nxt_periph;                                   // R2 R9
            converter_clk_en_out <= nxt_periph;                                   // R2
            wdt_clk_en_out       <= nxt_run;                                      // R2 R8
            sub_deriv_en_out     <= !nxt_stop;                                    // R2
            timer_clk_en_out     <= nxt_periph || timer_ext_event_in;             // R3
            serial_clk_en_out    <= nxt_periph || serial_ext_clk_in;              // R3
        end
    end

    // prescaler only advances with the peripheral clock enabled
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            pre_ff               <= '0;
            bus_pin_out          <= '1;
            port_pin_out         <= '0;
            clock_output_pin_out <= 1'b0;
        end
        else
        begin
            pre_ff               <= nxt_periph ? pre_ff + 1'b1 : pre_ff;         // R12
            bus_pin_out          <= nxt_bus;
            port_pin_out         <= nxt_run ? port_core_in : port_pin_out;        // R6 R11
            clock_output_pin_out <= nxt_cko;
        end
    end

    property p_stop_entry;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (state_ff == PMC_ST_RUN && stop_req_in) |=> stop_mode_out && !sub_osc_en_out;
    endproperty
    a_stop_entry: assert property (p_stop_entry) // R1
        else $error("stop request did not enter stop mode");

    property p_stop_clocks;
        @(posedge mclk_in) disable iff (!rst_b_in)
        stop_mode_out |-> !main_osc_en_out && !wdt_clk_en_out && !converter_clk_en_out
                          && !sub_deriv_en_out && !periph_clk_en_out && !bus_tick_out;
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) // R2
        else $error("a clock runs during stop mode");

    property p_stop_timer;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (stop_mode_out && $past(stop_mode_out)) |-> timer_clk_en_out == $past(timer_ext_event_in);
    endproperty
    a_stop_timer: assert property (p_stop_timer) // R3
        else $error("timer clock in stop does not follow external event mode");

    property p_wake;
        @(posedge mclk_in) disable iff (!rst_b_in)
        ((stop_mode_out || wait_mode_out) && irq_wake_in)
            |=> !stop_mode_out && !wait_mode_out && isr_start_out ##1 !isr_start_out;
    endproperty
    a_wake: assert property (p_wake) // R4
        else $error("interrupt did not wake to the service routine");

    property p_div8_force;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (state_ff == PMC_ST_RUN && stop_req_in && !ctrl_wr_in && !ctrl_out.system_clock_select)
            |=> ctrl_out.div8_select;
    endproperty
    a_div8_force: assert property (p_div8_force) // R5
        else $error("divide-by-8 not set on stop entry from main clock");

    property p_stop_pins;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (stop_mode_out && $past(stop_mode_out) && ext_bus_mode_in)
            |-> bus_pin_out.read_b && bus_pin_out.write_b && bus_pin_out.addr_latch
                && bus_pin_out.bus_clock && bus_pin_out.addr == $past(bus_pin_out.addr);
    endproperty
    a_stop_pins: assert property (p_stop_pins) // R6
        else $error("external bus pins not parked in stop");

    property p_cko_sub_stop;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (stop_mode_out && !ext_bus_mode_in && ctrl_out.clk_out_sel == `PMC_CKO_SUB)
            |-> clock_output_pin_out;
    endproperty
    a_cko_sub_stop: assert property (p_cko_sub_stop) // R7
        else $error("clock output not high in stop with sub-clock selected");

    property p_wait_entry;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (state_ff == PMC_ST_RUN && wait_instr_in && !stop_req_in)
            |=> wait_mode_out && !wdt_clk_en_out && sub_osc_en_out
                && (periph_clk_en_out == !(ctrl_out.wait_periph_clock_stop
                                           || ctrl_out.main_clock_stop));
    endproperty
    a_wait_entry: assert property (p_wait_entry) // R8 R9
        else $error("wait entry clock gating wrong");

    property p_wait_ctrl_stable;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (wait_mode_out && $past(wait_mode_out)) |-> $stable(ctrl_out);
    endproperty
    a_wait_ctrl_stable: assert property (p_wait_ctrl_stable) // R10
        else $error("clock selection changed during wait");

    property p_reset_div8;
        @(posedge mclk_in) disable iff (!rst_b_in)
        $past(!rst_b_in) |-> ctrl_out.div8_select && !stop_mode_out && !wait_mode_out;
    endproperty
    a_reset_div8: assert property (p_reset_div8) // R13
        else $error("reset did not select divide-by-8");

    c_stop_wake: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        stop_mode_out ##1 isr_start_out);
    c_wait_gated: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        wait_mode_out && !periph_clk_en_out);
    c_sub_tick: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        bus_tick_out && ctrl_out.system_clock_select);
    c_fast_div: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        bus_tick_out ##1 bus_tick_out);

endmodule : pmc_power_ctrl

`default_nettype wire

// [verilog/pmc_cfg.svh]
/*
 * pmc_cfg.svh - reset values, field codes and counter sizes for the
 * power mode and bus clock controller.
 * Assumes: included by bare name from the pmc design files that use its macros.
 */
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// control word reset: divide-by-8 forced, everything else clear
`define PMC_CTRL_RST    8'h08

// clock output pin select codes
`define PMC_CKO_PORT    2'h0
`define PMC_CKO_SUB     2'h1
`define PMC_CKO_F8      2'h2
`define PMC_CKO_F32     2'h3

// two-bit divider field codes when divide-by-8 is not forced
`define PMC_DIVF_1      2'h0
`define PMC_DIVF_2      2'h1
`define PMC_DIVF_4      2'h2
`define PMC_DIVF_16     2'h3

// last count of each main clock divider (ratio minus one)
`define PMC_CNT_W       4
`define PMC_LAST_DIV1   4'h0
`define PMC_LAST_DIV2   4'h1
`define PMC_LAST_DIV4   4'h3
`define PMC_LAST_DIV8   4'h7
`define PMC_LAST_DIV16  4'hF

// peripheral prescaler: f8 and f32 taps
`define PMC_PRE_W       5
`define PMC_F8_BIT      2
`define PMC_F32_BIT     4

`endif

// [verilog/pmc_pkg.sv]
/*
 * pmc_pkg.sv - types shared by the power mode and bus clock controller.
 * Assumes: compiled before every pmc module.
 */
`default_nettype none

package pmc_pkg;

    typedef enum logic [1:0] {
        PMC_ST_RUN  = 2'b00,
        PMC_ST_WAIT = 2'b01,
        PMC_ST_STOP = 2'b10
    } pmc_state_t;

    typedef enum logic [2:0] {
        PMC_SRC_DIV1  = 3'b000,
        PMC_SRC_DIV2  = 3'b001,
        PMC_SRC_DIV4  = 3'b010,
        PMC_SRC_DIV8  = 3'b011,
        PMC_SRC_DIV16 = 3'b100,
        PMC_SRC_SUB   = 3'b101
    } pmc_src_t;

    typedef struct packed {
        logic [1:0] clk_out_sel;
        logic       wait_periph_clock_stop;
        logic       main_clock_stop;
        logic       div8_select;
        logic       system_clock_select;
        logic       divider_field_high;
        logic       divider_field_low;
    } pmc_ctrl_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] data;
        logic        data_oe_b;
        logic [3:0]  chip_select_b;
        logic        byte_high_enable_b;
        logic        read_b;
        logic        write_b;
        logic        write_low_strobe_b;
        logic        write_high_strobe_b;
        logic        hold_acknowledge_b;
        logic        addr_latch;
        logic        bus_clock;
    } pmc_bus_t;

endpackage : pmc_pkg

`default_nettype wire

// [verilog/pmc_sync.sv]
/*
 * pmc_sync.sv - two flip-flop level synchroniser.
 * Assumes: async_in may change at any time relative to mclk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_b_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    // first stage is read only by the second stage
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            meta_ff  <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule : pmc_sync

`default_nettype wire

// [verilog/pmc_bclk_gen.sv]
/*
 * pmc_bclk_gen.sv - bus clock tick and phase generator with
 * switch-over only at period boundaries.
 * Assumes: sub_tick_in is a one-cycle pulse on each synced sub-clock rise.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"

module pmc_bclk_gen (
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_b_in,
    // control
    input  wire logic              run_in,
    input  wire pmc_pkg::pmc_src_t src_in,
    input  wire logic              sub_tick_in,
    input  wire logic              sub_lvl_in,
    // bus clock
    output logic                   tick_out,
    output logic                   phase_out
);
    import pmc_pkg::*;

    pmc_src_t               cur_src_ff;
    logic [`PMC_CNT_W-1:0]  cnt_ff;
    logic [`PMC_CNT_W-1:0]  last;
    logic [`PMC_CNT_W-1:0]  nxt_cnt;
    logic                   at_end;
    logic                   is_sub;

    // ratio of the source in use; a new source waits for the boundary
    assign last = (cur_src_ff == PMC_SRC_DIV1)  ? `PMC_LAST_DIV1 :
                  (cur_src_ff == PMC_SRC_DIV2)  ? `PMC_LAST_DIV2 :
                  (cur_src_ff == PMC_SRC_DIV4)  ? `PMC_LAST_DIV4 :
                  (cur_src_ff == PMC_SRC_DIV16) ? `PMC_LAST_DIV16 :
                                                  `PMC_LAST_DIV8;
    assign is_sub  = (cur_src_ff == PMC_SRC_SUB);
    assign at_end  = is_sub ? sub_tick_in : (cnt_ff == last);
    assign nxt_cnt = (at_end || is_sub) ? '0 : cnt_ff + 1'b1;

    // frozen while not running, so the bus clock simply stops
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            cur_src_ff <= PMC_SRC_DIV8;
            cnt_ff     <= '0;
            tick_out   <= 1'b0;
            phase_out  <= 1'b1;
        end
        else if (run_in)
        begin
            cnt_ff     <= nxt_cnt;
            tick_out   <= at_end;                              // R14
            phase_out  <= is_sub ? sub_lvl_in : (nxt_cnt <= (last >> 1));
            if (at_end)
                cur_src_ff <= src_in;                          // R19
        end
        else
        begin
            tick_out   <= 1'b0;
        end
    end

    property p_div4_period;
        @(posedge mclk_in) disable iff (!rst_b_in || !run_in)
        (tick_out && cur_src_ff == PMC_SRC_DIV4 && src_in == PMC_SRC_DIV4)
            |=> (!tick_out [*3]) ##1 tick_out;
    endproperty
    a_div4_period: assert property (p_div4_period) // R14
        else $error("divide-by-4 bus clock period is not four cycles");

    property p_no_short_pulse;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (tick_out && cur_src_ff == PMC_SRC_DIV16) |=> !tick_out;
    endproperty
    a_no_short_pulse: assert property (p_no_short_pulse) // R19
        else $error("bus clock period shorter than two cycles after divide-by-16");

endmodule : pmc_bclk_gen

`default_nettype wire

// [verif/pmc_power_ctrl_bench.sv]
/*
 * pmc_power_ctrl_bench.sv - self-checking bench for the power mode and bus clock controller.
 * Assumes: pmc_pkg and the pmc design files are compiled first; mclk_in runs at 100 MHz.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_power_ctrl_bench;
    import pmc_pkg::*;
    logic      mclk_in, rst_b_in, ctrl_wr_in, stop_req_in, wait_instr_in, irq_wake_in;
    logic      ext_bus_mode_in, timer_ext_event_in, serial_ext_clk_in, sub_clock_in;
    logic      cko_port_in, stop_mode_out, wait_mode_out, isr_start_out, bus_tick_out;
    logic      main_osc_en_out, sub_osc_en_out, periph_clk_en_out, converter_clk_en_out;
    logic      wdt_clk_en_out, sub_deriv_en_out, timer_clk_en_out, serial_clk_en_out;
    logic      clock_output_pin_out;
    logic [7:0] port_core_in, port_pin_out;
    pmc_ctrl_t ctrl_in, ctrl_out;
    pmc_bus_t  bus_core_in, bus_pin_out;
    int        bad_count, check_count, tk, fl;

    pmc_power_ctrl pmc_power_ctrl_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .ctrl_wr_in(ctrl_wr_in), .ctrl_in(ctrl_in), .stop_req_in(stop_req_in),
        .wait_instr_in(wait_instr_in), .irq_wake_in(irq_wake_in),
        .ext_bus_mode_in(ext_bus_mode_in), .timer_ext_event_in(timer_ext_event_in),
        .serial_ext_clk_in(serial_ext_clk_in), .sub_clock_in(sub_clock_in),
        .bus_core_in(bus_core_in), .port_core_in(port_core_in), .cko_port_in(cko_port_in),
        .ctrl_out(ctrl_out), .stop_mode_out(stop_mode_out), .wait_mode_out(wait_mode_out),
        .isr_start_out(isr_start_out), .main_osc_en_out(main_osc_en_out),
        .sub_osc_en_out(sub_osc_en_out), .periph_clk_en_out(periph_clk_en_out),
        .converter_clk_en_out(converter_clk_en_out), .wdt_clk_en_out(wdt_clk_en_out),
        .sub_deriv_en_out(sub_deriv_en_out), .timer_clk_en_out(timer_clk_en_out),
        .serial_clk_en_out(serial_clk_en_out), .bus_tick_out(bus_tick_out),
        .bus_pin_out(bus_pin_out), .port_pin_out(port_pin_out),
        .clock_output_pin_out(clock_output_pin_out));

    // main clock and a sub-clock of 160 ns period, off the main clock rising edges
    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    initial
    begin
        sub_clock_in = 1'b0;
        forever #80 sub_clock_in = ~sub_clock_in;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // inputs other than the sub-clock move 1 ns after the rising edge, outputs are settled by then
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] v);
        ctrl_in = v; ctrl_wr_in = 1'b1; cyc(1); ctrl_wr_in = 1'b0;
    endtask : wr

    task automatic pulse_mode(input logic stop);
        stop_req_in = stop; wait_instr_in = !stop; cyc(1);
        stop_req_in = 1'b0; wait_instr_in = 1'b0;
    endtask : pulse_mode

    // bounded search for a tick, then the cycle count to the next one
    task automatic spacing(input int exp);
        int n;
        n = 0;
        while (bus_tick_out !== 1'b1 && n < 100) begin cyc(1); n++; end
        n = 0;
        do begin cyc(1); n++; end while (bus_tick_out !== 1'b1 && n < 100);
        check(n, exp);
    endtask : spacing

    task automatic watch(input int n);
        logic last;
        tk = 0; fl = 0; last = clock_output_pin_out;
        repeat (n) begin cyc(1); tk += (bus_tick_out === 1'b1);
            fl += (clock_output_pin_out !== last); last = clock_output_pin_out; end
    endtask : watch

    // wake by interrupt: one cycle to leave the mode, service start lasts one cycle
    task automatic wake;
        irq_wake_in = 1'b1; cyc(1);
        check({stop_mode_out, wait_mode_out, isr_start_out}, 3'h1);
        irq_wake_in = 1'b0; cyc(1);
        check(isr_start_out, 1'h0);
    endtask : wake

    task automatic t_reset_and_dividers;
        int exp [4] = '{1, 2, 4, 16};
        check(ctrl_out, 8'h08);
        spacing(8);
        for (int c = 0; c < 4; c++) begin wr(8'(c)); cyc(40); spacing(exp[c]); end
        wr(8'h0B); cyc(40); spacing(8);
    endtask : t_reset_and_dividers

    task automatic t_stop_ext;
        ext_bus_mode_in = 1'b1; timer_ext_event_in = 1'b1; serial_ext_clk_in = 1'b0;
        bus_core_in = '0; bus_core_in.addr = 20'h5A5A5; port_core_in = 8'h3C;
        wr(8'h00); cyc(4); pulse_mode(1'b1);
        check({stop_mode_out, ctrl_out.div8_select}, 2'h3);
        bus_core_in.addr = 20'h0F0F0; port_core_in = 8'hC3; cyc(2);
        check({main_osc_en_out, sub_osc_en_out}, 2'h0);
        check({periph_clk_en_out, converter_clk_en_out, wdt_clk_en_out, sub_deriv_en_out}, 4'h0);
        check({timer_clk_en_out, serial_clk_en_out}, 2'h2);
        check({bus_pin_out.addr, port_pin_out}, {20'h5A5A5, 8'h3C});
        check({bus_pin_out.read_b, bus_pin_out.write_b, bus_pin_out.hold_acknowledge_b,
               bus_pin_out.addr_latch, bus_pin_out.bus_clock}, 5'h1F);
        watch(20); check(tk, 0);
        wake(); spacing(8);
    endtask : t_stop_ext

    task automatic t_stop_sub;
        ext_bus_mode_in = 1'b0; wr(8'h44); cyc(60); spacing(16);
        pulse_mode(1'b1); cyc(2);
        check({ctrl_out, clock_output_pin_out}, {8'h44, 1'b1});
        wake(); wr(8'h00); cyc(40);
    endtask : t_stop_sub

    task automatic t_wait;
        ext_bus_mode_in = 1'b1; wr(8'h21); cyc(40); pulse_mode(1'b0); cyc(1);
        check({wait_mode_out, wdt_clk_en_out, main_osc_en_out}, 3'h5);
        check({periph_clk_en_out, converter_clk_en_out}, 2'h0);
        check({bus_pin_out.write_b, bus_pin_out.bus_clock}, 2'h3);
        wr(8'h08); watch(20); check(tk, 0);
        wake(); check(ctrl_out, 8'h21); spacing(2);
        ext_bus_mode_in = 1'b0; wr(8'h80); cyc(4); pulse_mode(1'b0);
        watch(40); check({fl, periph_clk_en_out}, {32'd10, 1'b1});
        wake(); wr(8'hA0); cyc(4); pulse_mode(1'b0);
        watch(40); check(fl, 0);
        wake();
    endtask : t_wait

    task automatic report_and_stop;
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // main sequence: reset for two cycles, then each scenario in turn
    initial
    begin
        bad_count = 0; check_count = 0; rst_b_in = 1'b0; ctrl_wr_in = 1'b0; ctrl_in = '0;
        stop_req_in = 1'b0; wait_instr_in = 1'b0; irq_wake_in = 1'b0; ext_bus_mode_in = 1'b0;
        timer_ext_event_in = 1'b0; serial_ext_clk_in = 1'b0; cko_port_in = 1'b0;
        bus_core_in = '0; port_core_in = 8'h00;
        cyc(2); rst_b_in = 1'b1;
        t_reset_and_dividers(); t_stop_ext(); t_stop_sub(); t_wait();
        report_and_stop();
    end

    // the run needs about 650 cycles; far beyond that means a hang
    initial
    begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule : pmc_power_ctrl_bench

`default_nettype wire
